// ---- core/rxb_selftest_core.sv ----
/*
 * Receive self-test control and reporting: FIFO write suspension,
 * serial address flag handling, forced FIFO flags, loop progress on the
 * full flag, miscompare bit on the data bus and APB status registers.
 * Assumes a receive checker on the same clock giving character strobes,
 * pattern start, loop end and miscompare pulses, and FIFO status inputs.
 */
// Added by the designer: the register offsets and the APB register port.
`default_nettype none

`include "rxb_params.svh"

module rxb_selftest_core (
	input  wire logic              clock,
	input  wire logic              srst,
	input  wire logic [11:0]       paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic              rx_selftest_enable_n,
	input  wire logic              rx_if_clock,
	input  wire logic              addr_match_n,
	input  wire logic              rx_read_enable_n,
	input  wire logic              fifo_bypass_n,
	input  wire logic              timing_model_select,
	input  wire logic              rx_char_strobe,
	input  wire logic              rx_char_write,
	input  wire logic              rx_atomic_busy,
	input  wire logic              serial_addr_hit,
	input  wire logic              bist_start_det,
	input  wire logic              bist_loop_last,
	input  wire logic              bist_char_err,
	input  wire logic              fifo_empty_raw,
	input  wire logic              fifo_half_raw,
	input  wire logic              fifo_full_raw,
	input  wire logic [7:0]        fifo_rd_data,
	output var  logic              fifo_write_en,
	output var  logic              bypass_load,
	output var  logic              fifo_read_pop,
	output var  logic              rx_fifo_full_flag,
	output var  logic              rx_fifo_empty_flag,
	output var  logic              rx_fifo_half_flag,
	output var  logic              rx_flag_oe,
	output var  logic [7:0]        rx_parallel_bus,
	output var  logic              rx_violation_bit,
	output var  logic              rx_bus_oe,
	output var  rxb_pkg::rxb_loop_t loop_state
);
	import rxb_pkg::*;

	// ****************************************
	// Pin synchronisation
	// ****************************************
	logic [`RXB_PIN_COUNT-1:0] pins_s;
	logic                      ifclk_prev_q;

	rxb_sync #(
		.WIDTH  (`RXB_PIN_COUNT),
		.RST_VAL(`RXB_PIN_IDLE)
	) u_pin_sync (
		.clock     (clock),
		.srst      (srst),
		.pin_level ({rx_selftest_enable_n, rx_if_clock, addr_match_n,
			rx_read_enable_n, fifo_bypass_n, timing_model_select}),
		.sync_level(pins_s)
	);

	wire bist_req    = ~pins_s[5];
	wire ifclk_s     = pins_s[4];
	wire am_now      = ~pins_s[3];
	wire rd_en_s     = pins_s[2];
	wire bypass_on   = ~pins_s[1];
	// Cascade model selected by a low level
	wire cascade_on  = ~pins_s[0];
	wire rd_active   = cascade_on ? rd_en_s : ~rd_en_s;
	wire if_edge     = ifclk_s & ~ifclk_prev_q;

	// ****************************************
	// Self-test recognition and write gating
	// ****************************************
	logic       bist_q;
	logic       drop_q;
	logic       addr_flag_q;
	logic [7:0] mcast_q;

	wire bist_enter  = bist_req & ~bist_q;
	wire match_all   = (mcast_q == `RXB_MCAST_ALL);
	wire accept      = addr_flag_q | match_all;
	wire drop_d      = (bist_enter & rx_atomic_busy) | (drop_q & (rx_atomic_busy | bist_q));
	// New address hit wins over the clear
	wire addr_flag_d = serial_addr_hit | (addr_flag_q & ~bist_enter);
	// No FIFO writes while self-test is recognised
	wire store_ok    = rx_char_write & accept & ~bist_q & ~drop_q;

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			bist_q        <= 1'b0;
			drop_q        <= 1'b0;
			addr_flag_q   <= 1'b0;
			ifclk_prev_q  <= 1'b0;
			fifo_write_en <= 1'b0;
			bypass_load   <= 1'b0;
		end
		else
		begin
			bist_q        <= bist_req;
			drop_q        <= drop_d;
			addr_flag_q   <= addr_flag_d;
			ifclk_prev_q  <= ifclk_s;
			// Asynchronous configuration stores into the FIFO
			fifo_write_en <= store_ok & ~bypass_on;
			bypass_load   <= store_ok & bypass_on;
		end
	end

	// ****************************************
	// Loop progress and error window
	// ****************************************
	logic [`RXB_WIN_LEN-1:0] win_q;
	logic [4:0]              err_cnt_q;
	logic [15:0]             loops_q;
	rxb_loop_t               state_d;

	wire       win_shift = rx_char_strobe & (loop_state == LOOP_RUN);
	wire       err_in    = bist_char_err & win_shift;
	wire [4:0] err_cnt_d = win_shift ?
		5'(err_cnt_q + {4'h0, err_in} - {4'h0, win_q[`RXB_WIN_LEN-1]}) : err_cnt_q;
	// Too many misses inside the window
	wire       too_many  = win_shift & (err_cnt_d >= `RXB_ERR_LIMIT);
	wire       loop_end  = bist_loop_last & (loop_state == LOOP_RUN) & ~too_many;

	always_comb
	begin
		state_d = loop_state;
		case (loop_state)
			LOOP_IDLE:
				if (bist_enter)
					state_d = LOOP_HUNT;
			LOOP_HUNT:
				if (!bist_req)
					state_d = LOOP_IDLE;
				else if (bist_start_det)
					state_d = LOOP_RUN;
			LOOP_RUN:
				if (!bist_req)
					state_d = LOOP_IDLE;
				else if (too_many)
					state_d = LOOP_HUNT;
			default:
				state_d = LOOP_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			loop_state <= LOOP_IDLE;
			win_q      <= '0;
			err_cnt_q  <= 5'h00;
			loops_q    <= 16'h0000;
		end
		else
		begin
			loop_state <= state_d;
			// Window restarts on every fresh pattern start
			if (state_d != LOOP_RUN || loop_state != LOOP_RUN)
			begin
				win_q     <= '0;
				err_cnt_q <= 5'h00;
			end
			else if (win_shift)
			begin
				win_q     <= {win_q[`RXB_WIN_LEN-2:0], err_in};
				err_cnt_q <= err_cnt_d;
			end
			if (loop_end)
				loops_q <= 16'(loops_q + 16'h0001);
		end
	end

	// ****************************************
	// Host interface side
	// ****************************************
	logic full_pend_q;
	logic err_pend_q;
	logic rd_prev_q;

	// Entry and hunt set the flag, addressed or not
	wire full_set   = (state_d == LOOP_HUNT) | loop_end;
	wire err_set    = err_in;
	// Latched until an interface edge sees it: addressed for full, data bus enabled for the miscompare bit
	// Bypass keeps nothing past one interface edge
	wire full_take  = if_edge & (bypass_on | am_now);
	wire err_take   = if_edge & (bypass_on | rx_bus_oe);
	wire full_pend_d = full_set | (full_pend_q & ~full_take);
	wire err_pend_d  = err_set | (err_pend_q & ~err_take);
	// Full flag carries loop progress in self-test
	// Pulse lasts one interface clock period
	wire full_act   = bist_q ? (full_pend_q | full_set) : fifo_full_raw;
	// Real status once self-test is gone
	// FIFO reset cannot disturb the forced view
	wire empty_act  = bist_q | fifo_empty_raw;
	wire half_act   = ~bist_q & fifo_half_raw;
	wire sel_start  = rd_active & ~rd_prev_q & (rx_flag_oe | am_now);
	wire sel_d      = rd_active & (rx_bus_oe | sel_start);

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			full_pend_q        <= 1'b0;
			err_pend_q         <= 1'b0;
			rd_prev_q          <= 1'b0;
			rx_flag_oe         <= 1'b0;
			rx_bus_oe          <= 1'b0;
			rx_fifo_full_flag  <= 1'b1;
			rx_fifo_empty_flag <= 1'b1;
			rx_fifo_half_flag  <= 1'b1;
			rx_parallel_bus    <= 8'h00;
			rx_violation_bit   <= 1'b0;
			fifo_read_pop      <= 1'b0;
		end
		else
		begin
			full_pend_q   <= full_pend_d;
			err_pend_q    <= err_pend_d;
			fifo_read_pop <= if_edge & sel_d & ~bist_q & ~bypass_on & ~fifo_empty_raw;
			if (if_edge)
			begin
				rd_prev_q          <= rd_active;
				// Flag drivers follow the sampled match
				rx_flag_oe         <= am_now;
				// Data bus only for a selected read
				rx_bus_oe          <= sel_d;
				rx_fifo_full_flag  <= cascade_on ? full_act : ~full_act;
				rx_fifo_empty_flag <= cascade_on ? empty_act : ~empty_act;
				rx_fifo_half_flag  <= cascade_on ? half_act : ~half_act;
				rx_parallel_bus    <= bist_q ? 8'h00 : fifo_rd_data;
				rx_violation_bit   <= bist_q & (err_pend_q | err_set);
			end
		end
	end

	// ****************************************
	// APB slave, zero wait states
	// ****************************************
	wire        apb_setup = psel & ~penable;
	wire        apb_wr    = psel & penable & pready & pwrite;
	wire        hit_ctrl  = (paddr == `RXB_CTRL_OFF);
	wire        hit_stat  = (paddr == `RXB_STAT_OFF);
	wire        hit_loops = (paddr == `RXB_LOOPS_OFF);
	wire        hit_any   = hit_ctrl | hit_stat | hit_loops;
	wire [31:0] stat_word = {21'h000000, err_cnt_q, err_pend_q, full_pend_q,
		loop_state, addr_flag_q, bist_q};
	wire [31:0] rd_word   = hit_ctrl  ? {24'h000000, mcast_q} :
		hit_stat  ? stat_word :
		hit_loops ? {16'h0000, loops_q} : 32'h00000000;

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			mcast_q <= `RXB_MCAST_RST;
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= apb_setup;
			pslverr <= apb_setup & ~hit_any;
			prdata  <= (apb_setup & ~pwrite) ? rd_word : 32'h00000000;
			if (apb_wr && hit_ctrl)
				mcast_q <= pwdata[`RXB_MCAST_MSB:0];
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking chk_clk @(posedge clock); endclocking
	default disable iff (srst);

	chk_no_fifo_write: assert property (bist_q && $past(bist_q) |-> !fifo_write_en)
		else $error("FIFO written during self-test");
	chk_atomic_drop: assert property (drop_q && $past(drop_q) |-> !fifo_write_en && !bypass_load)
		else $error("Interrupted atomic data stored");
	chk_addr_clear: assert property (bist_enter && !serial_addr_hit |=> !addr_flag_q)
		else $error("Address flag survived self-test entry");
	chk_match_all: assert property (rx_char_write && match_all && !bist_q && !drop_q && !bypass_on
		|=> fifo_write_en)
		else $error("Match-all data rejected");
	chk_forced_empty: assert property (if_edge && bist_q |=> rx_fifo_empty_flag == $past(cascade_on)
		&& rx_fifo_half_flag == !$past(cascade_on))
		else $error("Flags not forced empty in self-test");
	chk_hunt_entry: assert property (bist_enter |=> loop_state == LOOP_HUNT ##0 full_pend_q)
		else $error("Self-test entry did not set full");
	chk_err_window: assert property (too_many && bist_req |=> loop_state == LOOP_HUNT)
		else $error("Error window did not return to hunt");
	chk_bypass_drop: assert property (full_take && bypass_on && !full_set |=> !full_pend_q)
		else $error("Bypass mode kept a loop event");
	chk_no_pop: assert property (bist_q |=> !fifo_read_pop)
		else $error("FIFO popped during self-test");
	chk_flag_oe: assert property (if_edge |=> rx_flag_oe == $past(am_now))
		else $error("Flag driver enable not following match");

	cov_entry: cover property (bist_enter ##[1:300] loop_state == LOOP_RUN);
	cov_loop: cover property (loop_end ##[1:100] if_edge);
	cov_rehunt: cover property (too_many);
	cov_select: cover property (bist_q && rx_bus_oe && rx_violation_bit);

endmodule : rxb_selftest_core

`default_nettype wire

// ---- core/rxb_params.svh ----
/*
 * Constants of the receive self-test reporting block: register offsets,
 * reset values, field positions and the error window figures.
 * Assumes inclusion by bare name from core and testbench files.
 */
`ifndef RXB_PARAMS_SVH
`define RXB_PARAMS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define RXB_CTRL_OFF     12'h000
`define RXB_STAT_OFF     12'h004
`define RXB_LOOPS_OFF    12'h008

// ****************************************
// Reset values and fields
// ****************************************
`define RXB_MCAST_RST    8'hff
`define RXB_MCAST_ALL    8'hff
`define RXB_MCAST_MSB    7

// ****************************************
// Self-test figures
// ****************************************
`define RXB_WIN_LEN      28
`define RXB_ERR_LIMIT    5'h0e
`define RXB_LOOP_LEN     511
`define RXB_SYNC_STAGES  2
`define RXB_PIN_COUNT    6
// Idle pin levels: test off, clock low, no match, read off, FIFO on, standard model
`define RXB_PIN_IDLE     6'h2f

`endif

// ---- core/rxb_pkg.sv ----
/*
 * Types shared by the receive self-test reporting block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package rxb_pkg;

	// Progress of the receive pattern loop
	typedef enum logic [1:0]
	{
		LOOP_IDLE,
		LOOP_HUNT,
		LOOP_RUN
	} rxb_loop_t;

endpackage : rxb_pkg

`default_nettype wire

// ---- core/rxb_sync.sv ----
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the inputs are levels from outside the clock domain.
 */
`default_nettype none

module rxb_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] pin_level,
	output var  logic [WIDTH-1:0] sync_level
);
	import rxb_pkg::*;

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clock)
	begin
		// Reset to idle levels, so no false request follows reset
		if (srst)
		begin
			meta_q     <= RST_VAL;
			sync_level <= RST_VAL;
		end
		else
		begin
			meta_q     <= pin_level;
			sync_level <= meta_q;
		end
	end

endmodule : rxb_sync

`default_nettype wire

// ---- testbench/rxb_host_model.sv ----
/* Host side of the receive interface: free running interface clock,
   address match and read enable. Assumes level requests from the bench. */
`default_nettype none

module rxb_host_model (
	input  wire logic model_sel,
	input  wire logic match_req,
	input  wire logic sel_req,
	output var  logic rx_if_clock,
	output var  logic addr_match_n,
	output var  logic rx_read_enable_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// ********
	// Host clock and controls
	// ********
	// Phase offset keeps it unrelated to the core clock
	initial
	begin
		rx_if_clock = 1'b0;
		#7.3;
		forever #62.5 rx_if_clock = ~rx_if_clock;
	end
	initial addr_match_n = 1'b1;
	initial rx_read_enable_n = 1'b1;
	// Falling edges, so levels are settled at each rising edge
	// Match low on host edges
	always @(negedge rx_if_clock) addr_match_n <= ~match_req;
	always @(negedge rx_if_clock)
		rx_read_enable_n <= (sel_req && addr_match_n == 1'b0) ? ~model_sel : model_sel;
endmodule : rxb_host_model

`default_nettype wire

// ---- testbench/rxb_selftest_core_tb_top.sv ----
/* Bench of the receive self-test core: APB tasks, pin stimulus, checks.
   Assumes the core files and the host model are compiled before it. */
`default_nettype none
`include "rxb_params.svh"

module rxb_selftest_core_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import rxb_pkg::*;
	// ********
	// Signals
	// ********
	logic        clock, srst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rng_q;
	logic        rx_selftest_enable_n, rx_if_clock, addr_match_n, rx_read_enable_n;
	logic        fifo_bypass_n, timing_model_select, rx_atomic_busy, match_req, sel_req;
	logic        rx_char_strobe, rx_char_write, serial_addr_hit, bist_start_det, bist_loop_last;
	logic        bist_char_err, fifo_empty_raw, fifo_half_raw, fifo_full_raw;
	logic        fifo_write_en, bypass_load, fifo_read_pop, rx_flag_oe, rx_violation_bit, rx_bus_oe;
	logic        rx_fifo_full_flag, rx_fifo_empty_flag, rx_fifo_half_flag;
	logic [7:0]  fifo_rd_data, rx_parallel_bus, rd_prev;
	logic [5:0]  pl;
	logic [32:0] exp_q[$];
	rxb_loop_t   loop_state;
	int          err_total, total_checks, wr_cnt, pop_cnt, ld_cnt;
	wire  [5:0]  obs = {rx_bus_oe, rx_violation_bit, rx_flag_oe,
	                    rx_fifo_half_flag, rx_fifo_empty_flag, rx_fifo_full_flag};
	assign {bist_char_err, bist_loop_last, bist_start_det, serial_addr_hit, rx_char_write, rx_char_strobe} = pl;

	rxb_host_model host (.model_sel(timing_model_select), .match_req, .sel_req,
		.rx_if_clock, .addr_match_n, .rx_read_enable_n);
	rxb_selftest_core uut (.clock, .srst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .rx_selftest_enable_n, .rx_if_clock, .addr_match_n,
		.rx_read_enable_n, .fifo_bypass_n, .timing_model_select, .rx_char_strobe,
		.rx_char_write, .rx_atomic_busy, .serial_addr_hit, .bist_start_det,
		.bist_loop_last, .bist_char_err, .fifo_empty_raw, .fifo_half_raw, .fifo_full_raw,
		.fifo_rd_data, .fifo_write_en, .bypass_load, .fifo_read_pop, .rx_fifo_full_flag,
		.rx_fifo_empty_flag, .rx_fifo_half_flag, .rx_flag_oe, .rx_parallel_bus,
		.rx_violation_bit, .rx_bus_oe, .loop_state);

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// ********
	// Tasks
	// ********
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic complete_run;
		if (err_total == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task automatic miss(input logic [32:0] e, input logic [32:0] g);
		err_total++;
		$display("[FAIL] %0t exp %h got %h", $time, e, g);
	endtask : miss

	task automatic cmp_apb;
		logic [32:0] e;
		e = exp_q.pop_front();
		total_checks++;
		if ({pslverr, prdata} !== e)
			miss(e, {pslverr, prdata});
	endtask : cmp_apb

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
			miss({1'b0, e}, {1'b0, g});
	endtask : chk_val

	// Polls an output; a stuck one ends the run
	task automatic wait_obs(input int k, input logic e);
		int n;
		n = 0;
		while (obs[k] !== e && n < 400)
		begin
			@(posedge clock);
			n++;
		end
		total_checks++;
		if (n >= 400)
		begin
			miss({32'h0, e}, {32'h0, obs[k]});
			complete_run();
		end
	endtask : wait_obs

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			miss(33'h1, 33'h0);
			complete_run();
		end
		@(posedge clock);
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask : rd

	task automatic pulse(input logic [5:0] v);
		pl <= v;
		@(posedge clock);
		pl <= 6'h00;
		repeat (4) @(posedge clock);
	endtask : pulse

	// Read results are matched in order against the queue
	always @(posedge clock)
	begin
		rng_q <= xs(rng_q);
		fifo_rd_data <= rng_q[7:0];
		rd_prev <= fifo_rd_data;
		if (fifo_write_en === 1'b1) wr_cnt++;
		if (bypass_load === 1'b1) ld_cnt++;
		if (fifo_read_pop === 1'b1) chk_val(32'(rx_parallel_bus), 32'(rd_prev));
		if (fifo_read_pop === 1'b1) pop_cnt++;
		if (psel && penable && pready === 1'b1 && !pwrite) cmp_apb();
	end
	// ********
	// Main sequence
	// ********
	initial
	begin
		rng_q = 32'hcffc;
		{srst, psel, penable, pwrite, paddr, pwdata, pl} = {1'b1, 53'h0};
		{rx_selftest_enable_n, fifo_bypass_n, timing_model_select, rx_atomic_busy} = 4'he;
		{fifo_empty_raw, fifo_half_raw, fifo_full_raw, fifo_rd_data} = {3'h2, 8'h00};
		{match_req, sel_req, err_total, total_checks, wr_cnt, pop_cnt, ld_cnt} = '0;
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		repeat (4) @(posedge clock);
		rd(`RXB_CTRL_OFF, 33'h0_0000_00ff);
		rd(`RXB_STAT_OFF, 33'h0);
		rd(12'h00c, 33'h1_0000_0000);
		apb(`RXB_STAT_OFF, 1'b1, rng_q);
		rd(`RXB_STAT_OFF, 33'h0);
		pulse(6'h02);
		chk_val(wr_cnt, 1);
		apb(`RXB_CTRL_OFF, 1'b1, 32'h0);
		pulse(6'h02);
		chk_val(wr_cnt, 1);
		pulse(6'h04);
		pulse(6'h02);
		chk_val(wr_cnt, 2);
		rd(`RXB_STAT_OFF, 33'h2);
		wait_obs(3, 1'b0);
		match_req <= 1'b1;
		wait_obs(3, 1'b1);
		wait_obs(1, 1'b1);
		rx_atomic_busy <= 1'b1;
		rx_selftest_enable_n <= 1'b0;
		wait_obs(0, 1'b0);
		wait_obs(1, 1'b0);
		wait_obs(2, 1'b1);
		chk_val(32'(loop_state), 32'(LOOP_HUNT));
		pulse(6'h02);
		chk_val(wr_cnt, 2);
		pulse(6'h08);
		wait_obs(0, 1'b1);
		pulse(6'h10);
		wait_obs(0, 1'b0);
		wait_obs(0, 1'b1);
		rd(`RXB_LOOPS_OFF, 33'h1);
		repeat (13) pulse(6'h21);
		chk_val(32'(loop_state), 32'(LOOP_RUN));
		pulse(6'h21);
		chk_val(32'(loop_state), 32'(LOOP_HUNT));
		wait_obs(0, 1'b0);
		wait_obs(5, 1'b0);
		sel_req <= 1'b1;
		wait_obs(5, 1'b1);
		wait_obs(4, 1'b1);
		chk_val(32'(rx_parallel_bus), 32'h0);
		chk_val(pop_cnt, 0);
		sel_req <= 1'b0;
		wait_obs(5, 1'b0);
		timing_model_select <= 1'b0;
		wait_obs(0, 1'b1);
		wait_obs(1, 1'b1);
		timing_model_select <= 1'b1;
		wait_obs(0, 1'b0);
		rx_selftest_enable_n <= 1'b1;
		wait_obs(1, 1'b1);
		wait_obs(2, 1'b0);
		pulse(6'h02);
		chk_val(wr_cnt, 2);
		pulse(6'h04);
		pulse(6'h02);
		chk_val(wr_cnt, 2);
		rx_atomic_busy <= 1'b0;
		@(posedge clock);
		pulse(6'h02);
		chk_val(wr_cnt, 3);
		sel_req <= 1'b1;
		wait_obs(5, 1'b1);
		repeat (60) @(posedge clock);
		chk_val(32'(pop_cnt != 0), 32'h1);
		sel_req <= 1'b0;
		wait_obs(5, 1'b0);
		fifo_bypass_n <= 1'b0;
		repeat (4) @(posedge clock);
		pulse(6'h02);
		chk_val(ld_cnt, 1);
		chk_val(wr_cnt, 3);
		complete_run();
	end
endmodule : rxb_selftest_core_tb_top

`default_nettype wire
